/* File: common/lfm_defs.svh */
`ifndef LFM_DEFS_SVH
`define LFM_DEFS_SVH
// Register byte offsets
`define LFM_CTRL_OFS    8'h00
`define LFM_MAX_OFS     8'h04
`define LFM_MIN_OFS     8'h08
`define LFM_HISP_OFS    8'h0c
`define LFM_LOSP_OFS    8'h10
`define LFM_DB_OFS      8'h14
`define LFM_DELAY_OFS   8'h18
`define LFM_MAN_OFS     8'h1c
`define LFM_PURGE_OFS   8'h20
`define LFM_PILOT_OFS   8'h24
`define LFM_MINF_OFS    8'h28
`define LFM_STAT_OFS    8'h2c
`define LFM_AUX_OFS     8'h30
`define LFM_FLAME_FAIL_RESPONSE_TIME_OFS    8'h34
`define LFM_TSP_OFS     8'h38
// Control field positions
`define LFM_CTRL_MODE_LSB  0
`define LFM_CTRL_LOCAL_BIT 2
`define LFM_CTRL_RST_BIT   3
`define LFM_CTRL_AUX_LSB   4
`define LFM_CTRL_OVR_BIT   7
// Reset values, level figures in 0.1 L
`define LFM_MAX_RST    16'h04b0
`define LFM_MIN_RST    16'h0000
`define LFM_HISP_RST   16'h0492
`define LFM_LOSP_RST   16'h0258
`define LFM_DB_RST     16'h000f
`define LFM_DELAY_RST  5'h02
`define LFM_DELAY_MIN  5'h02
`define LFM_DELAY_MAX  5'h14
`define LFM_MAN_RST    7'h00
`define LFM_PURGE_RST  7'h64
`define LFM_PILOT_RST  7'h19
`define LFM_MINF_RST   7'h28
`define LFM_MINF_MAX   7'h46
`define LFM_PCT_MAX    7'h64
`define LFM_TSP_RST    16'h03e8
`define LFM_FLAME_FAIL_RESPONSE_TIME_S     8'h04
// Timing and current scale in uA
`define LFM_SEC_NS     1000000000
`define LFM_CLK_NS     8
`define LFM_UA_LO      16'h0fa0
`define LFM_UA_HI      16'h4e20
`define LFM_UA_SPAN    16'h3e80
`define LFM_UA_PER_PCT 16'h00a0
`endif

/* File: common/lfm_pkg.sv */
`include "lfm_defs.svh"
package lfm_pkg;
   typedef enum logic [1:0] {
      LFM_IN_OFF = 2'h0,
      LFM_IN_DRY = 2'h1,
      LFM_IN_MA  = 2'h2
   } lfm_in_mode_t;
   typedef enum logic [2:0] {
      LFM_AUX_OFF = 3'h0, LFM_AUX_MAN = 3'h1, LFM_AUX_TEMP = 3'h2, LFM_AUX_PRESS = 3'h3,
      LFM_AUX_LEVEL = 3'h4, LFM_AUX_PID = 3'h5, LFM_AUX_FIRE = 3'h6
   } lfm_aux_mode_t;
   typedef enum logic [3:0] {
      LFM_ST_IDLE = 4'h1,
      LFM_ST_OK   = 4'h2,
      LFM_ST_PEND = 4'h4,
      LFM_ST_LOW  = 4'h8
   } lfm_mon_state_t;
   // Percent to loop current in uA, 0 % is 4 mA and 100 % is 20 mA
   function automatic logic [15:0] lfm_pct_to_ua(input logic [6:0] pct);
      lfm_pct_to_ua = 16'(`LFM_UA_LO + 16'(pct) * `LFM_UA_PER_PCT);
   endfunction
endpackage

/* File: design/lfm_aux_sel.sv */
`timescale 1ns/1ps
`include "lfm_defs.svh"
module lfm_aux_sel (
   // Configuration
   input  wire lfm_pkg::lfm_aux_mode_t mode_i,
   input  wire logic                  override_i,
   input  wire logic [6:0]            man_pct_i,
   input  wire logic [6:0]            purge_pct_i,
   input  wire logic [6:0]            pilot_pct_i,
   input  wire logic [6:0]            minf_pct_i,
   input  wire logic [15:0]           temp_sp_i,
   // Sources
   input  wire logic [15:0]           temp_i,
   input  wire logic [15:0]           press_ua_i,
   input  wire logic [15:0]           level_ua_i,
   input  wire logic [6:0]            pid_pct_i,
   input  wire logic [15:0]           fire_ua_i,
   input  wire logic                  purge_req_i,
   input  wire logic                  pilot_req_i,
   input  wire logic                  main_state_i,
   // Result
   output logic      [15:0]           ua_o,
   output logic                       en_o
);
   logic [31:0] tpct;
   logic [6:0]  tpct7;
   logic [15:0] base, minf_ua, pos;
   logic        pos_mode;

   // Temperature as percent of its high setpoint
   assign tpct  = (temp_sp_i == 16'h0) ? 32'(`LFM_PCT_MAX) : (32'(temp_i) * 32'h64) / 32'(temp_sp_i);
   assign tpct7 = (tpct > 32'(`LFM_PCT_MAX)) ? `LFM_PCT_MAX : tpct[6:0];
   // Position modes: presets, then floor in main
   assign pos_mode = (mode_i == lfm_pkg::LFM_AUX_PID) || (mode_i == lfm_pkg::LFM_AUX_FIRE);
   assign base     = (mode_i == lfm_pkg::LFM_AUX_FIRE) ? fire_ua_i :
                     lfm_pkg::lfm_pct_to_ua(pid_pct_i);
   assign minf_ua  = lfm_pkg::lfm_pct_to_ua(minf_pct_i);
   assign pos = purge_req_i ? lfm_pkg::lfm_pct_to_ua(purge_pct_i) :
                pilot_req_i ? lfm_pkg::lfm_pct_to_ua(pilot_pct_i) :
                (main_state_i && base < minf_ua) ? minf_ua : base;

   // Source choice, override first
   // An unused mode code drives nothing, like the disabled mode
   assign en_o = ((mode_i != lfm_pkg::LFM_AUX_OFF) && (mode_i <= lfm_pkg::LFM_AUX_FIRE)) ||
                 override_i;
   assign ua_o = (override_i || mode_i == lfm_pkg::LFM_AUX_MAN) ?
                    lfm_pkg::lfm_pct_to_ua(man_pct_i) :
                 (mode_i == lfm_pkg::LFM_AUX_TEMP)  ? lfm_pkg::lfm_pct_to_ua(tpct7) :
                 (mode_i == lfm_pkg::LFM_AUX_PRESS) ? press_ua_i :
                 (mode_i == lfm_pkg::LFM_AUX_LEVEL) ? level_ua_i :
                 pos_mode ? pos : 16'h0000;
endmodule // lfm_aux_sel

/* File: design/lfm_level_mon.sv */
`timescale 1ns/1ps
`include "lfm_defs.svh"
module lfm_level_mon #(
   parameter int unsigned TICKS_PER_SEC = `LFM_SEC_NS / `LFM_CLK_NS
) (
   // Clock and control
   input  wire logic                 ref_clk_i,
   input  wire logic                 rstn_i,
   input  wire logic                 ce_i,
   // Configuration
   input  wire lfm_pkg::lfm_in_mode_t mode_i,
   input  wire logic                 local_en_i,
   input  wire logic [15:0]          max_i,
   input  wire logic [15:0]          min_i,
   input  wire logic [15:0]          hi_sp_i,
   input  wire logic [15:0]          lo_sp_i,
   input  wire logic [15:0]          db_i,
   input  wire logic [4:0]           delay_s_i,
   // Inputs, own and from another controller
   input  wire logic                 sw_local_i,
   input  wire logic                 sw_remote_i,
   input  wire logic [15:0]          ua_local_i,
   input  wire logic [15:0]          ua_remote_i,
   // Results
   output logic      [15:0]          reading_o,
   output logic                      high_trip_o,
   output logic                      low_event_o,
   output logic                      low_act_o
);
   logic [15:0] ua_sel, ua_cl, span, db_eff, hi_eff, lo_eff;
   logic [31:0] prod, pre_r;
   logic        sw_sel, hi_r, lo_r, hi_nxt, lo_nxt, tick;
   logic [4:0]  sec_r;
   lfm_pkg::lfm_mon_state_t st_r, st_nxt;

   // Source and scaling
   assign ua_sel = local_en_i ? ua_local_i : ua_remote_i;
   assign sw_sel = local_en_i ? sw_local_i : sw_remote_i;
   assign ua_cl  = (ua_sel > `LFM_UA_HI) ? `LFM_UA_HI : ua_sel;
   assign span   = (max_i > min_i) ? 16'(max_i - min_i) : 16'h0000;
   assign prod   = (ua_cl > `LFM_UA_LO) ? 32'(ua_cl - `LFM_UA_LO) * 32'(span) : 32'h0;
   assign reading_o = 16'(min_i + 16'(prod / 32'(`LFM_UA_SPAN)));
   // Setpoints limited to max, deadband to a sixteenth of max
   assign hi_eff = (hi_sp_i > max_i) ? max_i : hi_sp_i;
   assign lo_eff = (lo_sp_i > max_i) ? max_i : lo_sp_i;
   assign db_eff = (db_i > (max_i >> 4)) ? (max_i >> 4) : db_i;
   // Event flags with hysteresis
   assign hi_nxt = (mode_i != lfm_pkg::LFM_IN_MA) ? 1'b0 :
                   hi_r ? ({1'b0, reading_o} + {1'b0, db_eff} > {1'b0, hi_eff}) :
                   (reading_o > hi_eff);
   assign lo_nxt = (mode_i == lfm_pkg::LFM_IN_OFF) ? 1'b0 :
                   (mode_i == lfm_pkg::LFM_IN_DRY) ? !sw_sel :
                   lo_r ? ({1'b0, reading_o} < {1'b0, lo_eff} + {1'b0, db_eff}) :
                   (reading_o < lo_eff);
   assign tick = (pre_r == TICKS_PER_SEC - 1);

   // Persistence state
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         lfm_pkg::LFM_ST_IDLE: if (mode_i != lfm_pkg::LFM_IN_OFF) st_nxt = lfm_pkg::LFM_ST_OK;
         lfm_pkg::LFM_ST_OK:   if (lo_r) st_nxt = lfm_pkg::LFM_ST_PEND;
         lfm_pkg::LFM_ST_PEND: if (!lo_r) st_nxt = lfm_pkg::LFM_ST_OK;
                               else if (sec_r >= delay_s_i) st_nxt = lfm_pkg::LFM_ST_LOW;
         lfm_pkg::LFM_ST_LOW:  if (!lo_r) st_nxt = lfm_pkg::LFM_ST_OK;
         default:              st_nxt = lfm_pkg::LFM_ST_IDLE;
      endcase
      if (mode_i == lfm_pkg::LFM_IN_OFF) st_nxt = lfm_pkg::LFM_ST_IDLE;
   end

   // State, flags and delay timer
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         st_r  <= lfm_pkg::LFM_ST_IDLE;
         hi_r  <= 1'b0;
         lo_r  <= 1'b0;
         pre_r <= 32'h0;
         sec_r <= 5'h00;
      end else if (ce_i) begin
         st_r  <= st_nxt;
         hi_r  <= hi_nxt;
         lo_r  <= lo_nxt;
         pre_r <= (st_r != lfm_pkg::LFM_ST_PEND || tick) ? 32'h0 : pre_r + 32'h1;
         sec_r <= (st_r != lfm_pkg::LFM_ST_PEND) ? 5'h00 : sec_r + 5'(tick);
      end
   end

   assign high_trip_o = hi_r;
   assign low_event_o = lo_r;
   assign low_act_o   = (st_r == lfm_pkg::LFM_ST_LOW);
endmodule // lfm_level_mon

/* File: design/lfm_top.sv */
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "lfm_defs.svh"
module lfm_top #(
   parameter int unsigned TICKS_PER_SEC = `LFM_SEC_NS / `LFM_CLK_NS
) (
   // Clock, reset and enable
   input  wire logic        ref_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        ce_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Level or flow input
   input  wire logic        lvl_sw_local_i,
   input  wire logic        lvl_sw_remote_i,
   input  wire logic [15:0] lvl_ua_local_i,
   input  wire logic [15:0] lvl_ua_remote_i,
   // Aux output sources
   input  wire logic [15:0] temp_i,
   input  wire logic [15:0] press_ua_i,
   input  wire logic [6:0]  pid_pct_i,
   input  wire logic [15:0] fire_ua_i,
   input  wire logic        purge_req_i,
   input  wire logic        pilot_req_i,
   input  wire logic        main_state_i,
   // Aux output
   output logic      [15:0] aux_ua_o,
   output logic             aux_en_o,
   // Appliance actions
   output logic             wait_o,
   output logic             shutdown_o,
   output logic             high_trip_o,
   output logic             low_event_o
);
   // Configuration registers
   logic [7:0]  ctrl_r;
   logic [15:0] max_r;
   logic [15:0] min_r;
   logic [15:0] hisp_r;
   logic [15:0] losp_r;
   logic [15:0] db_r;
   logic [4:0]  delay_r;
   logic [6:0]  man_r;
   logic [6:0]  purge_r;
   logic [6:0]  pilot_r;
   logic [6:0]  minf_r;
   logic [15:0] tsp_r;
   // Bus state
   logic        ack_r;
   logic [31:0] dat_r;
   // Output flops
   logic [15:0] aux_ua_r;
   logic        aux_en_r;
   logic        wait_r;
   logic        shut_r;
   logic        hi_r;
   logic        lo_r;
   // Decode wires
   logic        req;
   logic        wr;
   logic        rd_take;
   logic        wr_ctrl;
   logic        wr_max;
   logic        wr_min;
   logic        wr_hisp;
   logic        wr_losp;
   logic        wr_db;
   logic        wr_delay;
   logic        wr_man;
   logic        wr_purge;
   logic        wr_pilot;
   logic        wr_minf;
   logic        wr_tsp;
   logic [31:0] rd_mux;
   logic [31:0] wmask;
   logic [31:0] status;
   // Block wiring
   logic [15:0] reading;
   logic        mon_hi;
   logic        mon_lo;
   logic        mon_act;
   logic [15:0] sel_ua;
   logic        sel_en;
   logic        restart_en;
   logic        wait_nxt;
   logic        shut_nxt;
   logic [15:0] lvl_ua_sel;
   lfm_pkg::lfm_in_mode_t  in_mode;
   lfm_pkg::lfm_aux_mode_t aux_mode;

   // Byte-lane merge of a write into a register value
   function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] mask,
                                            input logic [31:0] wdat);
      wb_merge = (old & ~mask) | (wdat & mask);
   endfunction

   // Percent field limited to a ceiling
   function automatic logic [6:0] pct_lim(input logic [31:0] val, input logic [6:0] ceil);
      pct_lim = (val[6:0] > ceil || val[31:7] != 25'h0) ? ceil : val[6:0];
   endfunction

   // Delay limited to its legal seconds range
   function automatic logic [4:0] delay_lim(input logic [31:0] val);
      delay_lim = (val[31:5] != 27'h0 || val[4:0] > `LFM_DELAY_MAX) ? `LFM_DELAY_MAX :
                  (val[4:0] < `LFM_DELAY_MIN) ? `LFM_DELAY_MIN : val[4:0];
   endfunction

   // Bus request decode; writes land on the edge that sees ack
   assign req     = wb_cyc_i && wb_stb_i;
   assign rd_take = req && !ack_r;
   assign wr      = req && wb_we_i && ack_r;
   assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wr_ctrl  = wr && (wb_adr_i == `LFM_CTRL_OFS);
   assign wr_max   = wr && (wb_adr_i == `LFM_MAX_OFS);
   assign wr_min   = wr && (wb_adr_i == `LFM_MIN_OFS);
   assign wr_hisp  = wr && (wb_adr_i == `LFM_HISP_OFS);
   assign wr_losp  = wr && (wb_adr_i == `LFM_LOSP_OFS);
   assign wr_db    = wr && (wb_adr_i == `LFM_DB_OFS);
   assign wr_delay = wr && (wb_adr_i == `LFM_DELAY_OFS);
   assign wr_man   = wr && (wb_adr_i == `LFM_MAN_OFS);
   assign wr_purge = wr && (wb_adr_i == `LFM_PURGE_OFS);
   assign wr_pilot = wr && (wb_adr_i == `LFM_PILOT_OFS);
   assign wr_minf  = wr && (wb_adr_i == `LFM_MINF_OFS);
   assign wr_tsp   = wr && (wb_adr_i == `LFM_TSP_OFS);

   // Control fields
   assign in_mode    = lfm_pkg::lfm_in_mode_t'(ctrl_r[`LFM_CTRL_MODE_LSB +: 2]);
   assign aux_mode   = lfm_pkg::lfm_aux_mode_t'(ctrl_r[`LFM_CTRL_AUX_LSB +: 3]);
   assign restart_en = ctrl_r[`LFM_CTRL_RST_BIT];
   // Echoed level current follows the selected level source
   assign lvl_ua_sel = ctrl_r[`LFM_CTRL_LOCAL_BIT] ? lvl_ua_local_i : lvl_ua_remote_i;

   // Status word of live block state
   assign status = {reading, 10'h000, aux_en_r, shut_r, wait_r, mon_act, mon_lo, mon_hi};

   // Read selection; unmapped offsets read zero
   assign rd_mux =
      (wb_adr_i == `LFM_CTRL_OFS)  ? {24'h0, ctrl_r} :
      (wb_adr_i == `LFM_MAX_OFS)   ? {16'h0, max_r} :
      (wb_adr_i == `LFM_MIN_OFS)   ? {16'h0, min_r} :
      (wb_adr_i == `LFM_HISP_OFS)  ? {16'h0, hisp_r} :
      (wb_adr_i == `LFM_LOSP_OFS)  ? {16'h0, losp_r} :
      (wb_adr_i == `LFM_DB_OFS)    ? {16'h0, db_r} :
      (wb_adr_i == `LFM_DELAY_OFS) ? {27'h0, delay_r} :
      (wb_adr_i == `LFM_MAN_OFS)   ? {25'h0, man_r} :
      (wb_adr_i == `LFM_PURGE_OFS) ? {25'h0, purge_r} :
      (wb_adr_i == `LFM_PILOT_OFS) ? {25'h0, pilot_r} :
      (wb_adr_i == `LFM_MINF_OFS)  ? {25'h0, minf_r} :
      (wb_adr_i == `LFM_STAT_OFS)  ? status :
      (wb_adr_i == `LFM_AUX_OFS)   ? {16'h0, aux_ua_r} :
      (wb_adr_i == `LFM_FLAME_FAIL_RESPONSE_TIME_OFS)  ? {16'h0, `LFM_FLAME_FAIL_RESPONSE_TIME_S, `LFM_FLAME_FAIL_RESPONSE_TIME_S} :
      (wb_adr_i == `LFM_TSP_OFS)   ? {16'h0, tsp_r} : 32'h0;

   // Bus answer: ack one cycle after the request, then dropped
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0;
      end else if (ce_i) begin
         ack_r <= rd_take;
         if (rd_take) begin
            dat_r <= rd_mux;
         end
      end
   end

   // Control and level registers
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         ctrl_r  <= 8'h00;
         max_r   <= `LFM_MAX_RST;
         min_r   <= `LFM_MIN_RST;
         hisp_r  <= `LFM_HISP_RST;
         losp_r  <= `LFM_LOSP_RST;
         db_r    <= `LFM_DB_RST;
         delay_r <= `LFM_DELAY_RST;
      end else if (ce_i) begin
         if (wr_ctrl) ctrl_r <= 8'(wb_merge({24'h0, ctrl_r}, wmask, wb_dat_i));
         if (wr_max) max_r <= 16'(wb_merge({16'h0, max_r}, wmask, wb_dat_i));
         if (wr_min) min_r <= 16'(wb_merge({16'h0, min_r}, wmask, wb_dat_i));
         if (wr_hisp) hisp_r <= 16'(wb_merge({16'h0, hisp_r}, wmask, wb_dat_i));
         if (wr_losp) losp_r <= 16'(wb_merge({16'h0, losp_r}, wmask, wb_dat_i));
         if (wr_db) db_r <= 16'(wb_merge({16'h0, db_r}, wmask, wb_dat_i));
         if (wr_delay) delay_r <= delay_lim(wb_merge({27'h0, delay_r}, wmask, wb_dat_i));
      end
   end

   // Aux output setting registers
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         man_r   <= `LFM_MAN_RST;
         purge_r <= `LFM_PURGE_RST;
         pilot_r <= `LFM_PILOT_RST;
         minf_r  <= `LFM_MINF_RST;
         tsp_r   <= `LFM_TSP_RST;
      end else if (ce_i) begin
         if (wr_man) man_r <= pct_lim(wb_merge({25'h0, man_r}, wmask, wb_dat_i), `LFM_PCT_MAX);
         if (wr_purge) purge_r <= pct_lim(wb_merge({25'h0, purge_r}, wmask, wb_dat_i),
                                          `LFM_PCT_MAX);
         if (wr_pilot) pilot_r <= pct_lim(wb_merge({25'h0, pilot_r}, wmask, wb_dat_i),
                                          `LFM_PCT_MAX);
         if (wr_minf) minf_r <= pct_lim(wb_merge({25'h0, minf_r}, wmask, wb_dat_i),
                                        `LFM_MINF_MAX);
         if (wr_tsp) tsp_r <= 16'(wb_merge({16'h0, tsp_r}, wmask, wb_dat_i));
      end
   end

   // Level or flow monitor
   lfm_level_mon #(
      .TICKS_PER_SEC (TICKS_PER_SEC)
   ) u_mon (
      .ref_clk_i   (ref_clk_i),
      .rstn_i      (rstn_i),
      .ce_i        (ce_i),
      .mode_i      (in_mode),
      .local_en_i  (ctrl_r[`LFM_CTRL_LOCAL_BIT]),
      .max_i       (max_r),
      .min_i       (min_r),
      .hi_sp_i     (hisp_r),
      .lo_sp_i     (losp_r),
      .db_i        (db_r),
      .delay_s_i   (delay_r),
      .sw_local_i  (lvl_sw_local_i),
      .sw_remote_i (lvl_sw_remote_i),
      .ua_local_i  (lvl_ua_local_i),
      .ua_remote_i (lvl_ua_remote_i),
      .reading_o   (reading),
      .high_trip_o (mon_hi),
      .low_event_o (mon_lo),
      .low_act_o   (mon_act)
   );

   // Aux output source selection
   lfm_aux_sel u_aux (
      .mode_i       (aux_mode),
      .override_i   (ctrl_r[`LFM_CTRL_OVR_BIT]),
      .man_pct_i    (man_r),
      .purge_pct_i  (purge_r),
      .pilot_pct_i  (pilot_r),
      .minf_pct_i   (minf_r),
      .temp_sp_i    (tsp_r),
      .temp_i       (temp_i),
      .press_ua_i   (press_ua_i),
      .level_ua_i   (lvl_ua_sel),
      .pid_pct_i    (pid_pct_i),
      .fire_ua_i    (fire_ua_i),
      .purge_req_i  (purge_req_i),
      .pilot_req_i  (pilot_req_i),
      .main_state_i (main_state_i),
      .ua_o         (sel_ua),
      .en_o         (sel_en)
   );

   // Appliance actions on level events
   assign wait_nxt = mon_act && restart_en;
   assign shut_nxt = mon_hi || (mon_act && !restart_en);

   // Registered outputs
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         aux_ua_r <= 16'h0000;
         aux_en_r <= 1'b0;
         wait_r   <= 1'b0;
         shut_r   <= 1'b0;
         hi_r     <= 1'b0;
         lo_r     <= 1'b0;
      end else if (ce_i) begin
         aux_ua_r <= sel_en ? sel_ua : 16'h0000;
         aux_en_r <= sel_en;
         wait_r   <= wait_nxt;
         shut_r   <= shut_nxt;
         hi_r     <= mon_hi;
         lo_r     <= mon_lo;
      end
   end

   assign wb_ack_o    = ack_r;
   assign wb_dat_o    = dat_r;
   assign aux_ua_o    = aux_ua_r;
   assign aux_en_o    = aux_en_r;
   assign wait_o      = wait_r;
   assign shutdown_o  = shut_r;
   assign high_trip_o = hi_r;
   assign low_event_o = lo_r;
endmodule // lfm_top

/* File: verification/level_flow_monitor_aux_output_tb.sv */
`timescale 1ns/1ps
module level_flow_monitor_aux_output_tb;
   logic        ref_clk_i = 1'b0, rstn_i = 1'b0, cyc = 1'b0, we = 1'b0, ack;
   logic        sw_l = 1'b1, purge = 1'b0, pilot = 1'b0, main_s = 1'b0;
   logic        aux_en, wait_s, shut, hi, lo;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, dat_o;
   logic [15:0] lvl = 16'h0384, ua_r = 16'h3e80, press = 16'h1e61, fire = 16'h2328;
   logic [15:0] ua_l, aux_ua;
   logic [6:0]  pid = 7'h0a;
   logic [3:0]  flags;
   int          failures = 0, samples_checked = 0, n;
   // Clock
   always #4 ref_clk_i = ~ref_clk_i;
   // Design and transmitter
   lfm_top #(.TICKS_PER_SEC(10)) u_dut (
      .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .lvl_sw_local_i(sw_l), .lvl_sw_remote_i(1'b1), .lvl_ua_local_i(ua_l),
      .lvl_ua_remote_i(ua_r), .temp_i(16'h01f4), .press_ua_i(press), .pid_pct_i(pid),
      .fire_ua_i(fire), .purge_req_i(purge), .pilot_req_i(pilot), .main_state_i(main_s),
      .aux_ua_o(aux_ua), .aux_en_o(aux_en), .wait_o(wait_s), .shutdown_o(shut),
      .high_trip_o(hi), .low_event_o(lo));
   lfm_xmtr u_xmtr (.level_i(lvl), .ua_o(ua_l));
   // Flags for bounded waits: 0 low, 1 shutdown, 2 high, 3 wait
   assign flags = {wait_s, hi, shut, lo};
   // Compare and count
   task automatic chk(input string nm, input logic [15:0] e, g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // One classic bus cycle, held until ack
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge ref_clk_i);
         k++;
      end while (ack !== 1'b1 && k < 20);
      rdat = dat_o;
      if (ack !== 1'b1) begin
         failures++;
         give_verdict();
      end
      cyc <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      bus(1'b0, a, 32'h0);
      chk("register", e, rdat[15:0]);
   endtask
   // Bounded wait for a flag
   task automatic wait_hi(input int f);
      n = 0;
      while (flags[f] !== 1'b1 && n < 400) begin
         @(posedge ref_clk_i);
         n++;
      end
      if (flags[f] !== 1'b1) begin
         failures++;
         give_verdict();
      end
   endtask
   task automatic aux(input logic [7:0] c, input logic en, input logic [15:0] ua);
      bus(1'b1, 8'h00, {24'h0, c});
      repeat (2) @(posedge ref_clk_i);
      chk("aux_en", 16'(en), 16'(aux_en));
      chk("aux_ua", ua, aux_ua);
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      @(posedge ref_clk_i);
      rd(8'h04, 16'h04b0);
      rd(8'h08, 16'h0000);
      rd(8'h0c, 16'h0492);
      rd(8'h10, 16'h0258);
      rd(8'h14, 16'h000f);
      rd(8'h1c, 16'h0000);
      rd(8'h20, 16'h0064);
      rd(8'h24, 16'h0019);
      rd(8'h28, 16'h0028);
      rd(8'h34, 16'h0404);
      rd(8'h3c, 16'h0000);
      bus(1'b1, 8'h18, 32'h1f);
      rd(8'h18, 16'h0014);
      bus(1'b1, 8'h18, 32'h00);
      rd(8'h18, 16'h0002);
      $display("test settings done");
      bus(1'b1, 8'h00, 32'h06);
      lvl <= 16'h01f4;
      wait_hi(0);
      repeat (8) @(posedge ref_clk_i);
      chk("early act", 16'h0, 16'(shut));
      wait_hi(1);
      chk("delay", 16'h1, 16'(n > 9 && n < 16));
      lvl <= 16'h0262;
      repeat (6) @(posedge ref_clk_i);
      chk("low held", 16'h1, 16'(lo));
      lvl <= 16'h026c;
      repeat (4) @(posedge ref_clk_i);
      chk("low clear", 16'h0, 16'(lo));
      lvl <= 16'h049c;
      wait_hi(2);
      repeat (2) @(posedge ref_clk_i);
      chk("high shut", 16'h1, 16'(shut));
      lvl <= 16'h0384;
      $display("test transmitter done");
      bus(1'b1, 8'h00, 32'h0a);
      ua_r <= 16'h2710;
      wait_hi(3);
      ua_r <= 16'h3e80;
      repeat (6) @(posedge ref_clk_i);
      chk("wait clear", 16'h0, 16'(wait_s));
      $display("test remote done");
      bus(1'b1, 8'h00, 32'h05);
      sw_l <= 1'b0;
      wait_hi(0);
      bus(1'b1, 8'h00, 32'h04);
      repeat (6) @(posedge ref_clk_i);
      chk("off mode", 16'h0, 16'(lo));
      sw_l <= 1'b1;
      $display("test contact done");
      bus(1'b1, 8'h1c, 32'h1e);
      aux(8'h00, 1'b0, 16'h0000);
      aux(8'h10, 1'b1, 16'h2260);
      aux(8'h20, 1'b1, 16'h2ee0);
      aux(8'h30, 1'b1, 16'h1e61);
      aux(8'h40, 1'b1, 16'h3e80);
      aux(8'h50, 1'b1, 16'h15e0);
      main_s <= 1'b1;
      aux(8'h50, 1'b1, 16'h28a0);
      pilot <= 1'b1;
      aux(8'h50, 1'b1, 16'h1f40);
      purge <= 1'b1;
      aux(8'h50, 1'b1, 16'h4e20);
      purge  <= 1'b0;
      pilot  <= 1'b0;
      main_s <= 1'b0;
      aux(8'h60, 1'b1, 16'h2328);
      aux(8'hb0, 1'b1, 16'h2260);
      aux(8'h80, 1'b1, 16'h2260);
      $display("test aux done");
      give_verdict();
   end
endmodule // level_flow_monitor_aux_output_tb

/* File: verification/lfm_top_properties.sv */
`timescale 1ns/1ps
module lfm_chk (
   // Clock and bus
   input wire logic        ref_clk_i,
   input wire logic        rstn_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   // Results
   input wire logic [15:0] aux_ua_o,
   input wire logic        aux_en_o,
   input wire logic        wait_o,
   input wire logic        shutdown_o,
   input wire logic        high_trip_o,
   input wire logic        low_event_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   // Bus answers once, next cycle
   AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   // Aux output span
   AST_AUX_OFF: assert property (!aux_en_o |-> aux_ua_o == 16'h0000)
      else $error("aux not idle");
   AST_AUX_SPAN: assert property (aux_en_o |-> aux_ua_o inside {[16'h0fa0:16'h4e20]})
      else $error("aux out of span");
   // Level actions
   AST_HI_SHUT: assert property ($rose(high_trip_o) |-> ##[0:2] shutdown_o)
      else $error("no high shutdown");
   AST_LOW_HOLD: assert property ($rose(low_event_o) && !shutdown_o && !wait_o
      |=> (!shutdown_o && !wait_o) [*8])
      else $error("low acted early");
   AST_WAIT_CAUSE: assert property ($rose(wait_o) |-> $past(low_event_o))
      else $error("wait without event");
   AST_WAIT_CLR: assert property ($fell(low_event_o) |-> ##[0:3] !wait_o)
      else $error("wait stuck");
endmodule // lfm_chk
bind lfm_top lfm_chk u_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .aux_ua_o(aux_ua_o), .aux_en_o(aux_en_o),
   .wait_o(wait_o), .shutdown_o(shutdown_o), .high_trip_o(high_trip_o),
   .low_event_o(low_event_o));

/* File: verification/lfm_xmtr.sv */
`timescale 1ns/1ps
module lfm_xmtr #(
   parameter int unsigned MAX = 1200
) (
   // Level in 0.1 L
   input  wire logic [15:0] level_i,
   // Loop current in uA
   output logic      [15:0] ua_o
);
   // Linear loop current over 0 to MAX
   assign ua_o = 16'(32'h0fa0 + (32'(level_i) * 32'h3e80) / MAX);
endmodule // lfm_xmtr
